// ===== src/drat_pkg.sv
// Shared constants and types for the read auto precharge timing pair
package drat_pkg;
   localparam int BANK_W = 3;
   localparam int NB = 8;
   localparam int COL_W = 4;
   localparam int DQ_W = 16;
   localparam int LANE_W = 8;
   localparam int AL = 1;
   localparam int CL = 3;
   localparam int BL = 4;
   localparam int CK_PS = 50000;
   localparam int TRAS_PS = 40000;
   localparam int TRTP_PS = 7500;
   localparam int TRP_PS = 15000;
   localparam int TWR_PS = 15000;

   // Least times round up, never below one cycle
   function automatic int ck_up(input int ps);
      int n;
      n = (ps + CK_PS - 1) / CK_PS;
      if (n < 1) begin
         n = 1;
      end
      return n;
   endfunction

   localparam int TRAS_CK = ck_up(TRAS_PS);
   localparam int TRTP_CK = ck_up(TRTP_PS);
   localparam int TRP_CK = ck_up(TRP_PS);
   localparam int TWR_CK = ck_up(TWR_PS);
   localparam int TRTPRP_CK = ck_up(TRTP_PS + TRP_PS);
   localparam int RTP_MIN_CK = TRTP_CK > 2 ? TRTP_CK : 2;

   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACT = 3'h1,
      CMD_RD = 3'h2,
      CMD_WR = 3'h3,
      CMD_PRE = 3'h4
   } drat_cmd_e;
endpackage

// ===== src/drat_if.sv
// Command and data link between the controller end and the device end
`timescale 1ns/1ns
interface drat_if;
   import drat_pkg::*;
   drat_cmd_e cmd;
   logic [BANK_W-1:0] bank;
   logic [COL_W-1:0] col;
   logic a10;
   logic [DQ_W-1:0] dq_r_dev, dq_f_dev, dq_r_ctl, dq_f_ctl, dq_r, dq_f;
   logic dev_oe, ctl_oe;
   logic dqs_l_dev, dqs_u_dev, dqs_l_ctl, dqs_u_ctl, dqs_l, dqs_u;

   // Wire level resolved here so neither end floats a net
   assign dq_r = dev_oe ? dq_r_dev : (ctl_oe ? dq_r_ctl : '0);
   assign dq_f = dev_oe ? dq_f_dev : (ctl_oe ? dq_f_ctl : '0);
   assign dqs_l = dev_oe ? dqs_l_dev : (ctl_oe && dqs_l_ctl);
   assign dqs_u = dev_oe ? dqs_u_dev : (ctl_oe && dqs_u_ctl);

   modport dev (
      input cmd, bank, col, a10, dq_r, dq_f, dqs_l, dqs_u,
      output dq_r_dev, dq_f_dev, dev_oe, dqs_l_dev, dqs_u_dev
   );
   modport ctl (
      output cmd, bank, col, a10, dq_r_ctl, dq_f_ctl, ctl_oe, dqs_l_ctl, dqs_u_ctl,
      input dq_r, dq_f, dqs_l, dqs_u, dev_oe
   );
endinterface

// ===== src/drat_bank.sv
// Per-bank row and precharge timer of the device end
`timescale 1ns/1ns
module drat_bank #(
   parameter int AL = drat_pkg::AL,
   parameter int CL = drat_pkg::CL,
   parameter int BL = drat_pkg::BL
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Decoded commands for this bank, and the shared A10 bit
   input wire logic act,
   input wire logic rd,
   input wire logic wr,
   input wire logic pre,
   input wire logic ap,
   // Bank state
   output logic row_open,
   output logic prech,
   output logic ap_start
);
   import drat_pkg::*;
   localparam int WL = AL + CL - 1;
   localparam int RD_NOM = AL + BL / 2;
   localparam int RD_RTP = AL + BL / 2 - 2 + RTP_MIN_CK;
   localparam int RD_DUE = RD_RTP > RD_NOM ? RD_RTP : RD_NOM;
   localparam int WR_DUE = WL + BL / 2 + TWR_CK;
   logic [7:0] ras_age;
   logic [7:0] ap_age;
   logic [7:0] rp_left;
   logic ap_pend;
   logic ap_wr;
   logic ras_ok;
   logic ap_due;
   logic ap_go;

   assign ras_ok = ras_age >= 8'(TRAS_CK);
   assign ap_due = ap_age >= (ap_wr ? 8'(WR_DUE) : 8'(RD_DUE));
   assign ap_go = ap_pend && ap_due && ras_ok;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ras_age <= 8'h00;
      end else if (act) begin
         ras_age <= 8'h01;
      end else if (ras_age != 8'hFF) begin
         ras_age <= ras_age + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ap_pend <= 1'b0;
         ap_wr <= 1'b0;
         ap_age <= 8'h00;
      end else if ((rd || wr) && ap) begin
         ap_pend <= 1'b1;
         ap_wr <= wr;
         ap_age <= 8'h01;
      end else begin
         if (ap_go) begin
            ap_pend <= 1'b0;
         end
         if (ap_age != 8'hFF) begin
            ap_age <= ap_age + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         row_open <= 1'b0;
         prech <= 1'b0;
         rp_left <= 8'h00;
         ap_start <= 1'b0;
      end else begin
         ap_start <= ap_go;
         if (act) begin
            row_open <= 1'b1;
         end else if (ap_go || pre) begin
            row_open <= 1'b0;
            prech <= 1'b1;
            rp_left <= 8'(TRP_CK);
         end else if (rp_left == 8'h01) begin
            prech <= 1'b0;
            rp_left <= 8'h00;
         end else if (rp_left != 8'h00) begin
            rp_left <= rp_left - 8'h01;
         end
      end
   end
endmodule

// ===== src/drat_dev.sv
// Device end: command decode, bank timers, read and write bursts
`timescale 1ns/1ns
// Operation
// - A10 high on READ selects auto precharge
// - Precharge starts AL plus BL/2 after command
// - Start waits for tRAS and tRTP both
// - tRP counts from the actual precharge start
// - BL4 activate wait AL plus rounded tRTP+tRP
// - BL8 activate wait adds two more clocks
// - tRTP plus tRP rounded up to clocks
// - Precharge never before two clocks past prefetch
// - Banks run auto precharge concurrently
// - Other bank spacing: BL/2, BL/2+2, one
// - Explicit precharge only after tRAS elapsed
// - Lower strobe low byte, upper strobe high
// - Write latency is read latency minus one
// - Write with auto precharge closes row after
// - Read latency equals AL plus CL
// - Burst elements follow on successive clock edges
module drat_dev #(
   parameter int AL = drat_pkg::AL,
   parameter int CL = drat_pkg::CL,
   parameter int BL = drat_pkg::BL
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Link to the controller
   drat_if.dev link,
   // Bank status
   output logic [drat_pkg::NB-1:0] bank_open,
   output logic [drat_pkg::NB-1:0] bank_prech,
   output logic [drat_pkg::NB-1:0] ap_start,
   output logic cmd_err
);
   import drat_pkg::*;
   localparam int RL = AL + CL;
   localparam int WL = RL - 1;
   localparam int HB = BL / 2;
   localparam int MW = BANK_W + COL_W;
   localparam int EW = 1 + MW;
   logic [DQ_W-1:0] mem [2**MW];
   logic [EW-1:0] rpipe [RL-1];
   logic [EW-1:0] wpipe [WL];
   logic [EW-1:0] rtop;
   logic [EW-1:0] wtop;
   logic [BANK_W-1:0] rb_bank;
   logic [BANK_W-1:0] wb_bank;
   logic [COL_W-1:0] rb_col;
   logic [COL_W-1:0] wb_col;
   logic [7:0] rb_left;
   logic [7:0] wb_left;
   logic [NB-1:0] hit;
   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_pre;
   logic w_go;
   logic [BANK_W-1:0] w_bank;
   logic [COL_W-1:0] w_col;
   logic [MW-1:0] w_a0;
   logic [MW-1:0] w_a1;

   assign is_act = link.cmd == CMD_ACT;
   assign is_rd = link.cmd == CMD_RD;
   assign is_wr = link.cmd == CMD_WR;
   assign is_pre = link.cmd == CMD_PRE;
   assign hit = NB'(1) << link.bank;

   for (genvar b = 0; b < NB; b++) begin : g_bank
      drat_bank #(
         .AL(AL),
         .CL(CL),
         .BL(BL)
      ) u_bank (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .act(hit[b] && is_act),
         .rd(hit[b] && is_rd),
         .wr(hit[b] && is_wr),
         .pre(hit[b] && is_pre),
         .ap(link.a10),
         .row_open(bank_open[b]),
         .prech(bank_prech[b]),
         .ap_start(ap_start[b])
      );
   end

   // Flags protocol slips by the far side; state is not altered by it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_err <= 1'b0;
      end else begin
         cmd_err <= ((is_rd || is_wr) && !bank_open[link.bank])
            || (is_act && (bank_open[link.bank] || bank_prech[link.bank]));
      end
   end

   // Column command delay lines
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < RL - 1; i++) begin
            rpipe[i] <= '0;
         end
         for (int i = 0; i < WL; i++) begin
            wpipe[i] <= '0;
         end
      end else begin
         rpipe[0] <= {is_rd, link.bank, link.col};
         for (int i = 1; i < RL - 1; i++) begin
            rpipe[i] <= rpipe[i-1];
         end
         wpipe[0] <= {is_wr, link.bank, link.col};
         for (int i = 1; i < WL; i++) begin
            wpipe[i] <= wpipe[i-1];
         end
      end
   end

   assign rtop = rpipe[RL-2];
   assign wtop = wpipe[WL-1];

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rb_bank <= '0;
         rb_col <= '0;
         rb_left <= 8'h00;
         link.dq_r_dev <= '0;
         link.dq_f_dev <= '0;
         link.dev_oe <= 1'b0;
         link.dqs_l_dev <= 1'b0;
         link.dqs_u_dev <= 1'b0;
      end else if (rtop[EW-1]) begin
         link.dq_r_dev <= mem[rtop[MW-1:0]];
         link.dq_f_dev <= mem[{rtop[MW-1:COL_W], rtop[COL_W-1:0] + COL_W'(1)}];
         rb_bank <= rtop[MW-1:COL_W];
         rb_col <= rtop[COL_W-1:0] + COL_W'(2);
         rb_left <= 8'(HB - 1);
         link.dev_oe <= 1'b1;
         link.dqs_l_dev <= 1'b1;
         link.dqs_u_dev <= 1'b1;
      end else if (rb_left != 8'h00) begin
         link.dq_r_dev <= mem[{rb_bank, rb_col}];
         link.dq_f_dev <= mem[{rb_bank, rb_col + COL_W'(1)}];
         rb_col <= rb_col + COL_W'(2);
         rb_left <= rb_left - 8'h01;
      end else begin
         link.dev_oe <= 1'b0;
         link.dqs_l_dev <= 1'b0;
         link.dqs_u_dev <= 1'b0;
      end
   end

   assign w_go = wtop[EW-1] || wb_left != 8'h00;
   assign w_bank = wtop[EW-1] ? wtop[MW-1:COL_W] : wb_bank;
   assign w_col = wtop[EW-1] ? wtop[COL_W-1:0] : wb_col;
   assign w_a0 = {w_bank, w_col};
   assign w_a1 = {w_bank, w_col + COL_W'(1)};

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_bank <= '0;
         wb_col <= '0;
         wb_left <= 8'h00;
      end else if (wtop[EW-1]) begin
         wb_bank <= wtop[MW-1:COL_W];
         wb_col <= wtop[COL_W-1:0] + COL_W'(2);
         wb_left <= 8'(HB - 1);
      end else if (wb_left != 8'h00) begin
         wb_col <= wb_col + COL_W'(2);
         wb_left <= wb_left - 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (w_go && link.dqs_l) begin
         mem[w_a0][LANE_W-1:0] <= link.dq_r[LANE_W-1:0];
         mem[w_a1][LANE_W-1:0] <= link.dq_f[LANE_W-1:0];
      end
      if (w_go && link.dqs_u) begin
         mem[w_a0][DQ_W-1:LANE_W] <= link.dq_r[DQ_W-1:LANE_W];
         mem[w_a1][DQ_W-1:LANE_W] <= link.dq_f[DQ_W-1:LANE_W];
      end
   end
endmodule

// ===== src/drat_ctl.sv
// Controller end: request holding, command spacing, write data and read return
`timescale 1ns/1ns
module drat_ctl #(
   parameter int AL = drat_pkg::AL,
   parameter int CL = drat_pkg::CL,
   parameter int BL = drat_pkg::BL
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Link to the device
   drat_if.ctl link,
   // User request
   input wire logic req_valid,
   input wire drat_pkg::drat_cmd_e req_cmd,
   input wire logic [drat_pkg::BANK_W-1:0] req_bank,
   input wire logic [drat_pkg::COL_W-1:0] req_col,
   input wire logic req_ap,
   input wire logic [2*drat_pkg::DQ_W-1:0] req_wdata,
   output logic req_ready,
   // Read return
   output logic [2*drat_pkg::DQ_W-1:0] rd_data,
   output logic rd_valid
);
   import drat_pkg::*;
   localparam int WL = AL + CL - 1;
   localparam int HB = BL / 2;
   localparam int RDAP_SPEC = AL + HB - 2 + TRTPRP_CK;
   // Slow clocks let the two-clock floor outgrow the formula
   localparam int RD_FLOOR = AL + HB - 2 + RTP_MIN_CK + TRP_CK + 1;
   localparam int RDAP_ACT = RDAP_SPEC > RD_FLOOR ? RDAP_SPEC : RD_FLOOR;
   localparam int WRAP_ACT = WL + HB + TWR_CK + TRP_CK + 1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_WAIT = 2'h2
   } drat_st_e;
   drat_st_e state;
   drat_cmd_e p_cmd;
   logic [BANK_W-1:0] p_bank;
   logic [COL_W-1:0] p_col;
   logic p_ap;
   logic [2*DQ_W-1:0] p_wdata;
   logic [7:0] act_wait [NB];
   logic [7:0] pre_wait [NB];
   logic [NB-1:0] open_bank;
   logic [7:0] rd_wait;
   logic [7:0] wr_wait;
   logic [7:0] w_left;
   logic [2*DQ_W:0] w_pipe [WL];
   logic [7:0] ap_gap;
   logic ok;
   logic go;

   always_comb begin
      case (p_cmd)
         CMD_ACT: ok = !open_bank[p_bank] && act_wait[p_bank] == 8'h00;
         CMD_PRE: ok = open_bank[p_bank] && pre_wait[p_bank] == 8'h00;
         CMD_RD: ok = open_bank[p_bank] && rd_wait == 8'h00;
         CMD_WR: ok = open_bank[p_bank] && wr_wait == 8'h00;
         default: ok = 1'b1;
      endcase
   end
   assign go = state == ST_WAIT && ok;
   assign ap_gap = p_cmd == CMD_RD ? 8'(RDAP_ACT - 1) : 8'(WRAP_ACT - 1);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         req_ready <= 1'b1;
         p_cmd <= CMD_NOP;
         p_bank <= '0;
         p_col <= '0;
         p_ap <= 1'b0;
         p_wdata <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (req_valid) begin
                  p_cmd <= req_cmd;
                  p_bank <= req_bank;
                  p_col <= req_col;
                  p_ap <= req_ap;
                  p_wdata <= req_wdata;
                  state <= ST_WAIT;
                  req_ready <= 1'b0;
               end
            end
            ST_WAIT: begin
               if (ok) begin
                  state <= ST_IDLE;
                  req_ready <= 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
               req_ready <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         link.cmd <= CMD_NOP;
         link.bank <= '0;
         link.col <= '0;
         link.a10 <= 1'b0;
      end else begin
         link.cmd <= go ? p_cmd : CMD_NOP;
         link.bank <= p_bank;
         link.col <= p_col;
         link.a10 <= p_ap;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_wait <= 8'h00;
         wr_wait <= 8'h00;
         open_bank <= '0;
         for (int b = 0; b < NB; b++) begin
            act_wait[b] <= 8'h00;
            pre_wait[b] <= 8'h00;
         end
      end else begin
         if (rd_wait != 8'h00) begin
            rd_wait <= rd_wait - 8'h01;
         end
         if (wr_wait != 8'h00) begin
            wr_wait <= wr_wait - 8'h01;
         end
         for (int b = 0; b < NB; b++) begin
            if (act_wait[b] != 8'h00) begin
               act_wait[b] <= act_wait[b] - 8'h01;
            end
            if (pre_wait[b] != 8'h00) begin
               pre_wait[b] <= pre_wait[b] - 8'h01;
            end
         end
         if (go && (p_cmd == CMD_RD || p_cmd == CMD_WR)) begin
            rd_wait <= 8'(HB - 1);
            wr_wait <= p_cmd == CMD_RD ? 8'(HB + 1) : 8'(HB - 1);
         end
         if (go && p_cmd == CMD_ACT) begin
            open_bank[p_bank] <= 1'b1;
            pre_wait[p_bank] <= 8'(TRAS_CK - 1);
         end
         if (go && p_cmd == CMD_PRE) begin
            open_bank[p_bank] <= 1'b0;
            act_wait[p_bank] <= 8'(TRP_CK - 1);
         end
         if (go && (p_cmd == CMD_RD || p_cmd == CMD_WR) && p_ap) begin
            open_bank[p_bank] <= 1'b0;
            act_wait[p_bank] <= pre_wait[p_bank] + 8'(TRP_CK) > ap_gap ? pre_wait[p_bank] + 8'(TRP_CK) : ap_gap;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < WL; i++) begin
            w_pipe[i] <= '0;
         end
         w_left <= 8'h00;
         link.ctl_oe <= 1'b0;
         link.dq_r_ctl <= '0;
         link.dq_f_ctl <= '0;
         link.dqs_l_ctl <= 1'b0;
         link.dqs_u_ctl <= 1'b0;
      end else begin
         w_pipe[0] <= {go && p_cmd == CMD_WR, p_wdata};
         for (int i = 1; i < WL; i++) begin
            w_pipe[i] <= w_pipe[i-1];
         end
         if (w_pipe[WL-1][2*DQ_W]) begin
            {link.dq_f_ctl, link.dq_r_ctl} <= w_pipe[WL-1][2*DQ_W-1:0];
            w_left <= 8'(HB - 1);
            link.ctl_oe <= 1'b1;
            link.dqs_l_ctl <= 1'b1;
            link.dqs_u_ctl <= 1'b1;
         end else if (w_left != 8'h00) begin
            w_left <= w_left - 8'h01;
         end else begin
            link.ctl_oe <= 1'b0;
            link.dqs_l_ctl <= 1'b0;
            link.dqs_u_ctl <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else begin
         rd_valid <= link.dev_oe;
         rd_data <= {link.dq_f, link.dq_r};
      end
   end
endmodule

// ===== dv/drat_chk.sv
// Link protocol assertions for the controller and device ends
`timescale 1ns/1ns
module drat_chk #(
   parameter int AL = drat_pkg::AL,
   parameter int CL = drat_pkg::CL,
   parameter int BL = drat_pkg::BL
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Command
   input wire drat_pkg::drat_cmd_e cmd,
   input wire logic [drat_pkg::BANK_W-1:0] bank,
   input wire logic a10,
   // Data wire
   input wire logic dev_oe,
   input wire logic ctl_oe,
   input wire logic dqs_l,
   input wire logic dqs_u
);
   import drat_pkg::*;
   localparam int RL = AL + CL;
   localparam int WL = RL - 1;
   localparam int PUB_GAP = AL + BL / 2 - 2 + TRTPRP_CK;
   localparam int DEV_GAP = AL + BL / 2 - 2 + RTP_MIN_CK + TRP_CK + 1;
   localparam int RDAP_ACT = PUB_GAP > DEV_GAP ? PUB_GAP : DEV_GAP;

   // Age of the latest closing read; saturates so stale banks never trip
   logic [BANK_W-1:0] ap_bank;
   logic [7:0] ap_age;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ap_bank <= '0;
         ap_age <= 8'hFF;
      end else if (cmd == CMD_RD && a10) begin
         ap_bank <= bank;
         ap_age <= 8'h01;
      end else if (ap_age != 8'hFF) begin
         ap_age <= ap_age + 8'h01;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_rd_data;
      dev_oe [*2];
   endsequence
   sequence s_wr_data;
      ctl_oe [*2];
   endsequence

   property p_rd_burst;
      cmd == CMD_RD |-> ##RL s_rd_data;
   endproperty
   property p_rd_source;
      dev_oe |-> ($past(cmd, RL) == CMD_RD) || ($past(cmd, RL + 1) == CMD_RD);
   endproperty
   property p_wr_burst;
      cmd == CMD_WR |-> ##WL s_wr_data;
   endproperty
   property p_wr_source;
      ctl_oe |-> ($past(cmd, WL) == CMD_WR) || ($past(cmd, WL + 1) == CMD_WR);
   endproperty
   property p_no_clash;
      dev_oe |-> !ctl_oe;
   endproperty
   property p_rd_lanes;
      dev_oe |-> dqs_l && dqs_u;
   endproperty
   property p_wr_lanes;
      ctl_oe |-> dqs_l && dqs_u;
   endproperty
   property p_cmd_gap;
      cmd != CMD_NOP |=> cmd == CMD_NOP;
   endproperty
   property p_rd_wr_gap;
      cmd == CMD_RD |=> (cmd != CMD_WR) [*3];
   endproperty
   property p_rdap_act;
      cmd == CMD_ACT && bank == ap_bank |-> ap_age >= RDAP_ACT;
   endproperty

   a_rd_burst: assert property (p_rd_burst) else $error("read data late or short");
   a_rd_source: assert property (p_rd_source) else $error("read data without a read");
   a_wr_burst: assert property (p_wr_burst) else $error("write data late or short");
   a_wr_source: assert property (p_wr_source) else $error("write data without a write");
   a_no_clash: assert property (p_no_clash) else $error("both ends drive the data wire");
   a_rd_lanes: assert property (p_rd_lanes) else $error("read lane strobe missing");
   a_wr_lanes: assert property (p_wr_lanes) else $error("write lane strobe missing");
   a_cmd_gap: assert property (p_cmd_gap) else $error("commands on adjacent cycles");
   a_rd_wr_gap: assert property (p_rd_wr_gap) else $error("write too soon after read");
   a_rdap_act: assert property (p_rdap_act) else $error("activate too soon after closing read");
endmodule

// ===== dv/drat_tb.sv
// Self-checking bench: controller end and device end joined by the link
`timescale 1ns/1ns
module tb;
   import drat_pkg::*;
   localparam int RL = AL + CL;
   localparam int KRD = (AL + BL / 2 > AL + BL / 2 - 2 + RTP_MIN_CK) ? AL + BL / 2 : AL + BL / 2 - 2 + RTP_MIN_CK;
   localparam int AP_RD = KRD + 1;
   localparam int AP_WR = RL - 1 + BL / 2 + TWR_CK + 1;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   drat_cmd_e req_cmd = CMD_NOP;
   logic [BANK_W-1:0] req_bank = '0;
   logic [COL_W-1:0] req_col = '0;
   logic req_ap = 1'b0;
   logic [2*DQ_W-1:0] req_wdata = '0;
   logic req_ready, rd_valid, cmd_err, exp_v;
   logic [2*DQ_W-1:0] rd_data;
   logic [NB-1:0] bank_open, bank_prech, ap_start;
   logic [NB-1:0] open_m = '0;
   logic [DQ_W-1:0] mem[NB][1<<COL_W];
   logic [2*DQ_W-1:0] rd_q[$];
   int rd_t[$];
   int ap_due[NB] = '{default: -1};
   int cols[NB];
   int failures = 0;
   int comparisons = 0;
   int cyc = 0;
   int err_due = -1;
   int bk, cl;
   // Own picks for the random loop; bk and cl belong to the link model
   int rbk, rcl;
   logic [31:0] seed = 32'h34;

   always #25 sys_clk = ~sys_clk;

   drat_if drat_if_inst();
   drat_dev #(.AL(AL), .CL(CL), .BL(BL)) drat_dev_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(drat_if_inst), .bank_open(bank_open), .bank_prech(bank_prech), .ap_start(ap_start), .cmd_err(cmd_err));
   drat_ctl #(.AL(AL), .CL(CL), .BL(BL)) drat_ctl_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(drat_if_inst), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_col(req_col),
      .req_ap(req_ap), .req_wdata(req_wdata), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid));
   drat_chk #(.AL(AL), .CL(CL), .BL(BL)) drat_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .cmd(drat_if_inst.cmd), .bank(drat_if_inst.bank), .a10(drat_if_inst.a10), .dev_oe(drat_if_inst.dev_oe),
      .ctl_oe(drat_if_inst.ctl_oe), .dqs_l(drat_if_inst.dqs_l), .dqs_u(drat_if_inst.dqs_u));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic results();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp_data(input logic [2*DQ_W-1:0] got, input logic [2*DQ_W-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t read pair %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flag(input logic [NB-1:0] got, input logic [NB-1:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One request, held until the controller takes it; write data lands in the model
   task automatic issue(input drat_cmd_e c, input int b, input int col, input logic ap);
      int n;
      logic [2*DQ_W-1:0] d;
      n = 0;
      d = xs();
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_bank <= b[BANK_W-1:0];
      req_col <= col[COL_W-1:0];
      req_ap <= ap;
      req_wdata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      if (n >= 50) begin
         failures++;
         $display("BAD %0t request never taken", $time);
         results();
      end
      if (c == CMD_WR) begin
         for (int k = 0; k < BL; k++) begin
            mem[b][(col + k) % (1 << COL_W)] = k[0] ? d[2*DQ_W-1:DQ_W] : d[DQ_W-1:0];
         end
      end
   endtask

   task automatic settle_open();
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp_flag(bank_open, open_m, "open banks");
   endtask

   // Device model fed from the link, compared every cycle
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (!sys_rst) begin
         for (int b = 0; b < NB; b++) begin
            cmp_flag(ap_start[b], ap_due[b] == cyc, "ap start");
            if (ap_due[b] == cyc) begin
               cmp_flag(bank_prech[b], 1'b1, "prech start");
               open_m[b] = 1'b0;
            end
            if (ap_due[b] + TRP_CK == cyc) begin
               cmp_flag(bank_prech[b], 1'b0, "prech end");
            end
         end
         cmp_flag(cmd_err, err_due == cyc, "cmd err");
         exp_v = rd_t.size() > 0 && rd_t[0] == cyc;
         cmp_flag(rd_valid, exp_v, "read valid");
         if (exp_v) begin
            void'(rd_t.pop_front());
            cmp_data(rd_data, rd_q.pop_front());
         end
         bk = int'(drat_if_inst.bank);
         cl = int'(drat_if_inst.col);
         if (drat_if_inst.cmd == CMD_ACT) begin
            if (open_m[bk]) begin
               err_due = cyc + 1;
            end
            open_m[bk] = 1'b1;
         end
         if (drat_if_inst.cmd == CMD_PRE) begin
            open_m[bk] = 1'b0;
         end
         if (drat_if_inst.cmd == CMD_RD || drat_if_inst.cmd == CMD_WR) begin
            if (!open_m[bk]) begin
               err_due = cyc + 1;
            end
            // close after the burst, later for writes
            if (drat_if_inst.a10) begin
               ap_due[bk] = cyc + (drat_if_inst.cmd == CMD_RD ? AP_RD : AP_WR);
            end
         end
         if (drat_if_inst.cmd == CMD_RD) begin
            for (int k = 0; k < BL / 2; k++) begin
               rd_q.push_back({mem[bk][(cl + 2 * k + 1) % (1 << COL_W)], mem[bk][(cl + 2 * k) % (1 << COL_W)]});
               rd_t.push_back(cyc + RL + 1 + k);
            end
         end
      end
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int b = 0; b < NB; b++) begin
         cols[b] = int'(xs() % (1 << COL_W));
         issue(CMD_ACT, b, 0, 1'b0);
      end
      for (int b = 0; b < NB; b++) begin
         issue(CMD_WR, b, cols[b], 1'b0);
      end
      // Back-to-back reads, odd banks closing while the rest stay active
      for (int b = 0; b < NB; b++) begin
         issue(CMD_RD, b, cols[b], b[0]);
      end
      issue(CMD_ACT, 7, 0, 1'b0);
      settle_open();
      issue(CMD_ACT, 1, 0, 1'b0);
      issue(CMD_WR, 1, cols[1], 1'b1);
      issue(CMD_WR, 7, cols[7], 1'b1);
      issue(CMD_RD, 0, cols[0], 1'b1);
      issue(CMD_WR, 4, cols[4], 1'b0);
      issue(CMD_RD, 4, cols[4], 1'b0);
      for (int b = 2; b < NB; b += 2) begin
         issue(CMD_PRE, b, 0, 1'b0);
      end
      settle_open();
      // Random banks and columns, each row opened, written, read and closed
      for (int i = 0; i < 12; i++) begin
         rbk = int'(xs() % NB);
         rcl = int'(xs() % (1 << COL_W));
         issue(CMD_ACT, rbk, 0, 1'b0);
         issue(CMD_WR, rbk, rcl, 1'b0);
         issue(CMD_RD, rbk, rcl, 1'b1);
      end
      settle_open();
      cmp_flag(rd_q.size() == 0, 1'b1, "reads left over");
      results();
   end
endmodule
